// File: core/display_ram.sv
// Purpose: embedded display buffer, one write port and one read port
// Assumes: both ports on the same clock; read data one cycle after request
// Notes:   writes beyond the buffer size are dropped
`timescale 1ns/10ps
module display_ram #(
    parameter int BYTES = 81920
) (
    input  wire logic                      ref_clk_i,
    input  wire logic                      rst_b_i,
    input  wire logic                      wr_en_i,
    input  wire viewport_pkg::start_addr_t wr_addr_i,
    input  wire logic [7:0]                wr_data_i,
    input  wire logic                      rd_en_i,
    input  wire viewport_pkg::start_addr_t rd_addr_i,
    output logic [7:0]                     rd_data_o,
    output logic                           rd_valid_o
);
    import viewport_pkg::*;

    logic [7:0] mem_q [BYTES];

    if (BYTES < 2 || BYTES > 131072) begin : g_bad_size
        $error("display_ram: BYTES must fit a 17-bit address");
    end

    // host writes into the buffer
    always_ff @(posedge ref_clk_i) begin
        if (wr_en_i && (32'(wr_addr_i) < BYTES)) begin
            mem_q[wr_addr_i] <= wr_data_i;
        end
    end

    // registered read port
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_data_o  <= 8'h00;
            rd_valid_o <= 1'b0;
        end else begin
            rd_valid_o <= rd_en_i;
            if (rd_en_i) begin
                rd_data_o <= mem_q[rd_addr_i];
            end
        end
    end

endmodule : display_ram

// File: core/viewport_cfg.svh
// Purpose: register indices, field positions and reset values of the
//          viewport start-address block
// Assumes: byte address on the bus is four times the register index
// Notes:   definitions only
`ifndef VIEWPORT_CFG_SVH
`define VIEWPORT_CFG_SVH

// register indices (byte address = index * 4)
`define IDX_CTRL        5'h01
`define IDX_START_LOW   5'h0C
`define IDX_START_MID   5'h0D
`define IDX_START_HIGH  5'h10
`define IDX_LINE_OFS    5'h11
`define IDX_WIDTH       5'h12
`define IDX_STATUS      5'h13

// control register fields
`define CTRL_PORTRAIT_BIT   0
`define CTRL_BPP_LSB        1
`define CTRL_BPP_MSB        2

// status register fields
`define STAT_START_MSB      16
`define STAT_STEP_LSB       24
`define STAT_STEP_MSB       28

// reset values
`define CTRL_RST        3'h0
`define START_BYTE_RST  8'h00
`define START_HIGH_RST  1'h0
`define LINE_OFS_RST    8'h00
`define WIDTH_RST       10'h0A0

// size of the embedded display buffer in bytes
`define BUF_BYTES_DEF   81920

`endif

// File: core/viewport_pkg.sv
// Purpose: shared types of the viewport start-address block
// Assumes: nothing beyond the configuration header
// Notes:   numeric constants live in viewport_cfg.svh
package viewport_pkg;

    // 17-bit start address or buffer byte address
    typedef logic [16:0] start_addr_t;

    // colour depth selector: 1, 2, 4 or 8 bits per pixel
    typedef enum logic [1:0] {
        BPP_1 = 2'h0,
        BPP_2 = 2'h1,
        BPP_4 = 2'h2,
        BPP_8 = 2'h3
    } bpp_sel_t;

    // display fetch engine states (gray along idle -> active)
    typedef enum logic {
        FETCH_IDLE   = 1'b0,
        FETCH_ACTIVE = 1'b1
    } fetch_state_t;

endpackage : viewport_pkg

// File: core/viewport_start.sv
// Purpose: screen 1 start-address registers and display fetch addressing
// Assumes: frame_start_i and pixel_req_i come from panel timing on ref_clk_i
// Notes:   registers on Avalon-MM with waitrequest, one word per register
//
// Notes on behaviour
// - start address is low byte, middle byte, and bit 0 of the third
// - landscape: start address counts 16-bit words into display memory
// - portrait: start address counts bytes into display memory
// - landscape step is one word of pixels: 16, 8, 4 or 2
// - portrait step is one byte of pixels: 8, 4, 2 or 1
// - each frame fetch starts at the start address, top-left pixel
// - after each line skip line-offset extra words; zero means none
// - fetches come from an embedded buffer of 81920 bytes
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/10ps
`include "viewport_cfg.svh"
module viewport_start #(
    parameter int BUF_BYTES = `BUF_BYTES_DEF
) (
    input  wire logic                      ref_clk_i,
    input  wire logic                      rst_b_i,
    // register bus
    input  wire logic [6:0]                avs_address_i,
    input  wire logic                      avs_read_i,
    input  wire logic                      avs_write_i,
    input  wire logic [31:0]               avs_writedata_i,
    input  wire logic [3:0]                avs_byteenable_i,
    output logic [31:0]                    avs_readdata_o,
    output logic                           avs_waitrequest_o,
    // display memory fill port
    input  wire logic                      mem_wr_i,
    input  wire viewport_pkg::start_addr_t mem_waddr_i,
    input  wire logic [7:0]                mem_wdata_i,
    // panel timing
    input  wire logic                      frame_start_i,
    input  wire logic                      pixel_req_i,
    // fetched display data
    output logic [7:0]                     pix_data_o,
    output logic                           pix_valid_o,
    output logic                           frame_busy_o
);
    import viewport_pkg::*;

    if (BUF_BYTES < 2 || BUF_BYTES > 131072) begin : g_bad_buf
        $error("viewport_start: BUF_BYTES must fit a 17-bit address");
    end

    // software-visible registers
    logic [7:0]   start_low_q;
    logic [7:0]   start_mid_q;
    logic         start_high_q;
    logic [7:0]   line_ofs_q;
    logic [9:0]   width_q;
    logic         portrait_q;
    bpp_sel_t     bpp_q;
    logic         wait_q;
    logic [31:0]  rd_mux;
    logic [4:0]   step_pix;
    logic [4:0]   reg_idx;
    logic         wr_take;
    logic         rd_take;
    start_addr_t  start_word;

    // fetch engine state
    fetch_state_t state_q;
    start_addr_t  act_start_q;
    start_addr_t  line_base_q;
    start_addr_t  addr_q;
    logic [9:0]   col_q;
    logic         col_last;
    logic         fetch_go;
    start_addr_t  frame_base;
    start_addr_t  next_line;

    // reduce an 18-bit offset into the buffer
    function automatic start_addr_t mod_buf(input logic [17:0] x);
        logic [31:0] t;
        t = {14'h0, x} % BUF_BYTES;
        return t[16:0];
    endfunction : mod_buf

    // bus decode; a write is taken in the cycle waitrequest is low, a read in the wait cycle
    assign reg_idx    = avs_address_i[6:2];
    assign wr_take    = avs_write_i && !wait_q;
    assign rd_take    = avs_read_i && wait_q;
    assign start_word = {start_high_q, start_mid_q, start_low_q};

    // pixels moved per unit of start address
    always_comb begin
        if (portrait_q) begin
            step_pix = 5'h08 >> bpp_q;
        end else begin
            step_pix = 5'h10 >> bpp_q;
        end
    end

    // waitrequest: one wait cycle, answer in the next
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wait_q <= 1'b1;
        end else if ((avs_read_i || avs_write_i) && wait_q) begin
            wait_q <= 1'b0;
        end else begin
            wait_q <= 1'b1;
        end
    end
    assign avs_waitrequest_o = wait_q;

    // start-address registers; held here until the next frame start
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            start_low_q  <= `START_BYTE_RST;
            start_mid_q  <= `START_BYTE_RST;
            start_high_q <= `START_HIGH_RST;
        end else if (wr_take && avs_byteenable_i[0]) begin
            case (reg_idx)
                `IDX_START_LOW:  start_low_q  <= avs_writedata_i[7:0];
                `IDX_START_MID:  start_mid_q  <= avs_writedata_i[7:0];
                `IDX_START_HIGH: start_high_q <= avs_writedata_i[0];
                default: ;
            endcase
        end
    end

    // line offset, control and width registers
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            line_ofs_q <= `LINE_OFS_RST;
            width_q    <= `WIDTH_RST;
            portrait_q <= 1'(`CTRL_RST >> `CTRL_PORTRAIT_BIT);
            bpp_q      <= bpp_sel_t'(2'(`CTRL_RST >> `CTRL_BPP_LSB));
        end else if (wr_take) begin
            if (reg_idx == `IDX_LINE_OFS && avs_byteenable_i[0]) begin
                line_ofs_q <= avs_writedata_i[7:0];
            end
            if (reg_idx == `IDX_WIDTH && avs_byteenable_i[0]) begin
                width_q[7:0] <= avs_writedata_i[7:0];
            end
            if (reg_idx == `IDX_WIDTH && avs_byteenable_i[1]) begin
                width_q[9:8] <= avs_writedata_i[9:8];
            end
            if (reg_idx == `IDX_CTRL && avs_byteenable_i[0]) begin
                portrait_q <= avs_writedata_i[`CTRL_PORTRAIT_BIT];
                bpp_q      <= bpp_sel_t'(
                    avs_writedata_i[`CTRL_BPP_MSB:`CTRL_BPP_LSB]);
            end
        end
    end

    // read mux; unmapped indices read as zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (reg_idx)
            `IDX_CTRL:       rd_mux[2:0] = {bpp_q, portrait_q};
            `IDX_START_LOW:  rd_mux[7:0] = start_low_q;
            `IDX_START_MID:  rd_mux[7:0] = start_mid_q;
            `IDX_START_HIGH: rd_mux[0]   = start_high_q;
            `IDX_LINE_OFS:   rd_mux[7:0] = line_ofs_q;
            `IDX_WIDTH:      rd_mux[9:0] = width_q;
            `IDX_STATUS: begin
                rd_mux[`STAT_START_MSB:0] = act_start_q;
                rd_mux[`STAT_STEP_MSB:`STAT_STEP_LSB] = step_pix;
            end
            default:         rd_mux = 32'h0000_0000;
        endcase
    end

    // read data is loaded as the wait cycle ends
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (rd_take) begin
            avs_readdata_o <= rd_mux;
        end
    end

    // frame base: words in landscape, bytes in portrait
    always_comb begin
        if (portrait_q) begin
            frame_base = mod_buf({1'b0, start_word});
        end else begin
            frame_base = mod_buf({start_word, 1'b0});
        end
    end

    // next line: displayed width plus extra offset words
    assign next_line = mod_buf(18'(line_base_q) + 18'(width_q)
                               + 18'({line_ofs_q, 1'b0}));
    assign col_last  = ({1'b0, col_q} + 11'h001) >= {1'b0, width_q};
    assign fetch_go  = (state_q == FETCH_ACTIVE) && pixel_req_i
                       && !frame_start_i;

    // frame state: a frame runs from frame_start_i until the next one
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q <= FETCH_IDLE;
        end else begin
            case (state_q)
                FETCH_IDLE:   if (frame_start_i) state_q <= FETCH_ACTIVE;
                FETCH_ACTIVE: state_q <= FETCH_ACTIVE;
                default:      state_q <= FETCH_IDLE;
            endcase
        end
    end
    assign frame_busy_o = (state_q == FETCH_ACTIVE);

    // start address is captured only at a frame start
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            act_start_q <= 17'h0_0000;
        end else if (frame_start_i) begin
            act_start_q <= start_word;
        end
    end

    // fetch address walk along lines of the frame
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            line_base_q <= 17'h0_0000;
            addr_q      <= 17'h0_0000;
            col_q       <= 10'h000;
        end else if (frame_start_i) begin
            line_base_q <= frame_base;
            addr_q      <= frame_base;
            col_q       <= 10'h000;
        end else if (fetch_go) begin
            if (col_last) begin
                line_base_q <= next_line;
                addr_q      <= next_line;
                col_q       <= 10'h000;
            end else begin
                addr_q <= mod_buf(18'(addr_q) + 18'h0_0001);
                col_q  <= col_q + 10'h001;
            end
        end
    end

    // embedded display buffer
    display_ram #(
        .BYTES      (BUF_BYTES)
    ) display_ram_inst (
        .ref_clk_i  (ref_clk_i),
        .rst_b_i    (rst_b_i),
        .wr_en_i    (mem_wr_i),
        .wr_addr_i  (mem_waddr_i),
        .wr_data_i  (mem_wdata_i),
        .rd_en_i    (fetch_go),
        .rd_addr_i  (addr_q),
        .rd_data_o  (pix_data_o),
        .rd_valid_o (pix_valid_o)
    );

    // checks
    property p_start_capture;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        frame_start_i |=> act_start_q == $past(start_word);
    endproperty
    a_start_capture: assert property (p_start_capture)
        else $error("start address not captured at frame start");

    property p_land_words;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (frame_start_i && !portrait_q) |=>
            32'(line_base_q) == ((32'($past(start_word)) * 2) % BUF_BYTES);
    endproperty
    a_land_words: assert property (p_land_words)
        else $error("landscape base is not twice the start address");

    property p_port_bytes;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (frame_start_i && portrait_q) |=>
            32'(line_base_q) == (32'($past(start_word)) % BUF_BYTES);
    endproperty
    a_port_bytes: assert property (p_port_bytes)
        else $error("portrait base is not the start address");

    property p_step_land;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        !portrait_q |-> (int'(step_pix) << int'(bpp_q)) == 16;
    endproperty
    a_step_land: assert property (p_step_land)
        else $error("landscape step is not one word of pixels");

    property p_step_port;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        portrait_q |-> (int'(step_pix) << int'(bpp_q)) == 8;
    endproperty
    a_step_port: assert property (p_step_port)
        else $error("portrait step is not one byte of pixels");

    property p_frame_top_left;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        frame_start_i |=> (addr_q == line_base_q) && (col_q == 10'h000)
                          && (state_q == FETCH_ACTIVE);
    endproperty
    a_frame_top_left: assert property (p_frame_top_left)
        else $error("frame does not start at the top-left pixel");

    property p_line_skip;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (fetch_go && col_last) |=>
            32'(line_base_q) == ((32'($past(line_base_q))
                + 32'($past(width_q)) + 32'($past(line_ofs_q)) * 2)
                % BUF_BYTES);
    endproperty
    a_line_skip: assert property (p_line_skip)
        else $error("line did not skip the offset words");

    property p_fetch_data;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        fetch_go |=> pix_valid_o ##0 (32'($past(addr_q)) < BUF_BYTES);
    endproperty
    a_fetch_data: assert property (p_fetch_data)
        else $error("fetch outside buffer or missing data");

    property p_hold_start;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        !frame_start_i |=> $stable(act_start_q);
    endproperty
    a_hold_start: assert property (p_hold_start)
        else $error("start address changed inside a frame");

    property p_readback;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (avs_read_i && !wait_q && reg_idx == `IDX_START_LOW) |->
            avs_readdata_o == {24'h00_0000, start_low_q};
    endproperty
    a_readback: assert property (p_readback)
        else $error("start low register did not read back");

    c_write_start: cover property (@(posedge ref_clk_i) disable iff
        (!rst_b_i) wr_take && reg_idx == `IDX_START_HIGH);
    c_line_wrap: cover property (@(posedge ref_clk_i) disable iff
        (!rst_b_i) fetch_go && col_last && line_ofs_q != 8'h00);
    c_portrait_frame: cover property (@(posedge ref_clk_i) disable iff
        (!rst_b_i) frame_start_i && portrait_q ##1 fetch_go);

endmodule : viewport_start

// File: tb/test_display_viewport_start_address.sv
// Purpose: self-checking bench of the viewport start-address block
// Assumes: one wait cycle per register access; fetch output follows request
// Notes:   expected values come from the register map and fetch arithmetic
`timescale 1ns/10ps
`include "viewport_cfg.svh"
module test_display_viewport_start_address;
    import viewport_pkg::*;

    localparam int BUF = 81920;

    logic        clk            = 1'b0;
    logic        rst_b          = 1'b0;
    logic [6:0]  avs_address    = 7'h00;
    logic        avs_read       = 1'b0;
    logic        avs_write      = 1'b0;
    logic [31:0] avs_writedata  = 32'h0;
    logic [3:0]  avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        mem_wr         = 1'b0;
    start_addr_t mem_waddr      = 17'h0;
    logic [7:0]  mem_wdata      = 8'h00;
    logic        frame_start    = 1'b0;
    logic        pixel_req      = 1'b0;
    logic [7:0]  pix_data;
    logic        pix_valid;
    logic        frame_busy;
    int          error_cnt      = 0;
    int          n_checks       = 0;
    logic [31:0] rd;
    int          v;

    viewport_start viewport_start_inst (
        .ref_clk_i(clk), .rst_b_i(rst_b),
        .avs_address_i(avs_address), .avs_read_i(avs_read),
        .avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
        .avs_byteenable_i(avs_byteenable), .avs_readdata_o(avs_readdata),
        .avs_waitrequest_o(avs_waitrequest), .mem_wr_i(mem_wr),
        .mem_waddr_i(mem_waddr), .mem_wdata_i(mem_wdata),
        .frame_start_i(frame_start), .pixel_req_i(pixel_req),
        .pix_data_o(pix_data), .pix_valid_o(pix_valid),
        .frame_busy_o(frame_busy)
    );

    // 10 MHz clock
    always #50 clk = ~clk;

    // buffer content seen at a byte address
    function automatic logic [7:0] pat(input int a);
        return 8'(a) ^ 8'(a >> 8) ^ 8'(a >> 16);
    endfunction : pat

    task automatic check(input logic [31:0] got, exp, input string what);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : tally_and_finish

    // request held until waitrequest is sampled low
    task automatic bus_write(input logic [4:0] idx, input logic [31:0] d,
                             input logic [3:0] be = 4'hF);
        @(posedge clk);
        avs_address    <= {idx, 2'b00};
        avs_writedata  <= d;
        avs_byteenable <= be;
        avs_write      <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask : bus_write

    task automatic bus_read(input logic [4:0] idx, output logic [31:0] d);
        @(posedge clk);
        avs_address <= {idx, 2'b00};
        avs_read    <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_read <= 1'b0;
    endtask : bus_read

    task automatic set_start(input int s);
        bus_write(`IDX_START_LOW, 32'(s & 8'hFF));
        bus_write(`IDX_START_MID, 32'((s >> 8) & 8'hFF));
        bus_write(`IDX_START_HIGH, 32'((s >> 16) & 1));
    endtask : set_start

    task automatic get_start(output int s);
        logic [31:0] b0, b1, b2;
        bus_read(`IDX_START_LOW, b0);
        bus_read(`IDX_START_MID, b1);
        bus_read(`IDX_START_HIGH, b2);
        s = int'({b2[0], b1[7:0], b0[7:0]});
    endtask : get_start

    task automatic frame_pulse();
        @(posedge clk);
        frame_start <= 1'b1;
        @(posedge clk);
        frame_start <= 1'b0;
    endtask : frame_pulse

    task automatic fill(input int a, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            mem_wr    <= 1'b1;
            mem_waddr <= 17'(a + i);
            mem_wdata <= pat(a + i);
        end
        @(posedge clk);
        mem_wr <= 1'b0;
    endtask : fill

    // pan or scroll by read-modify-write, clamping at zero
    task automatic move(input int delta);
        int s;
        get_start(s);
        s = s + delta;
        if (s < 0)
            s = 0;
        set_start(s);
        get_start(v);
        check(32'(v), 32'(s), "start after move");
    endtask : move

    // one frame of n fetches; compares each byte with its buffer place
    task automatic run_frame(input int base, w, lofs, n);
        int got_n;
        int a;
        got_n = 0;
        frame_pulse();
        pixel_req <= 1'b1;
        for (int c = 0; c < n + 6; c++) begin
            @(posedge clk);
            if (c == n - 1)
                pixel_req <= 1'b0;
            if (pix_valid === 1'b1) begin
                a = (base + (got_n / w) * (w + 2 * lofs) + got_n % w) % BUF;
                check({24'h0, pix_data}, {24'h0, pat(a)}, "fetched byte");
                got_n++;
            end
        end
        check(32'(got_n), 32'(n), "fetch count");
        check({31'h0, frame_busy}, 32'h1, "busy after frame start");
    endtask : run_frame

    // watchdog
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        tally_and_finish();
    end

    // main sequence
    initial begin
        repeat (2) @(posedge clk);
        check({31'h0, avs_waitrequest}, 32'h1, "wait in reset");
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        bus_read(`IDX_START_LOW, rd);
        check(rd, 32'h0, "low after reset");
        bus_read(`IDX_START_HIGH, rd);
        check(rd, 32'h0, "high after reset");
        bus_read(`IDX_WIDTH, rd);
        check(rd, 32'h0A0, "width after reset");
        bus_read(5'h1F, rd);
        check(rd, 32'h0, "unmapped read");
        $display("test reset done");

        bus_write(`IDX_START_LOW, 32'hA5);
        bus_write(`IDX_START_MID, 32'h3C);
        bus_write(`IDX_START_HIGH, 32'hFF);
        bus_write(`IDX_START_LOW, 32'h11, 4'hE);
        get_start(v);
        check(32'(v), 32'h13CA5, "assembled start");
        bus_read(`IDX_START_HIGH, rd);
        check(rd, 32'h1, "unused high bits");
        bus_read(`IDX_STATUS, rd);
        check({15'h0, rd[16:0]}, 32'h0, "held before frame");
        frame_pulse();
        bus_read(`IDX_STATUS, rd);
        check({15'h0, rd[16:0]}, 32'h13CA5, "applied at frame");
        $display("test registers done");

        for (int m = 0; m < 8; m++) begin
            bus_write(`IDX_CTRL, 32'(m));
            frame_pulse();
            bus_read(`IDX_STATUS, rd);
            v = (m & 1) ? (8 >> (m >> 1)) : (16 >> (m >> 1));
            check({27'h0, rd[28:24]}, 32'(v), "pixels per step");
        end
        $display("test steps done");

        fill(32'h200, 32);
        fill(65541, 8);
        fill(81918, 2);
        fill(0, 2);
        @(posedge clk);
        mem_wr    <= 1'b1;
        mem_waddr <= 17'(BUF);
        mem_wdata <= 8'h5A;
        @(posedge clk);
        mem_wr <= 1'b0;
        bus_write(`IDX_CTRL, 32'h0);
        bus_write(`IDX_WIDTH, 32'h4);
        bus_write(`IDX_LINE_OFS, 32'h2);
        set_start(32'h100);
        run_frame(32'h200, 4, 2, 12);
        bus_write(`IDX_LINE_OFS, 32'h0);
        bus_write(`IDX_CTRL, 32'h1);
        set_start(65541);
        run_frame(65541, 4, 0, 8);
        bus_write(`IDX_CTRL, 32'h0);
        set_start(40959);
        run_frame(81918, 4, 0, 4);
        $display("test fetch done");

        bus_write(`IDX_LINE_OFS, 32'h2);
        set_start(1);
        move(-1);
        move(-1);
        move(1);
        move(4);
        move(-4);
        move(-4);
        frame_pulse();
        bus_read(`IDX_STATUS, rd);
        check({15'h0, rd[16:0]}, 32'h0, "clamped start applied");
        $display("test pan and scroll done");
        tally_and_finish();
    end

endmodule : test_display_viewport_start_address
